// *** shp_device.sv ***
// Chosen here: register access over the serial link.
`timescale 1ns/10ps
`default_nettype none
module shp_device #(
  parameter int N_GPIO       = shp_pkg::N_GPIO_DEF,
  parameter int STRAP_CYCLES = shp_pkg::STRAP_HOLD_CYC
) (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       arst_n,
  // serial link and pins
  spi_if.dev                              link,
  // clock control outputs
  output logic [shp_pkg::N_STOP-1:0]      clk_stop,
  output logic [shp_pkg::N_DIFF-1:0]      diff_en,
  output logic [shp_pkg::N_CMOS-1:0]      cmos_en,
  // interface selection status
  output logic                            strap_done,
  output logic                            host_if_i2c
);
  import shp_pkg::*;

  typedef enum logic [3:0] {
    ST_OFF  = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_WR   = 4'b0100,
    ST_RD   = 4'b1000
  } dev_state_t;

  logic              cs_s1_q, cs_s2_q, cs_prev_q;
  logic              sck_s1_q, sck_s2_q, sck_prev_q;
  logic              si_s1_q, si_s2_q;
  logic [N_GPIO-1:0] gp_s1_q, gp_s2_q;
  logic [31:0]       strap_cnt_q;
  dev_state_t        state_q;
  logic [2:0]        cnt_q;
  logic [7:0]        sh_q;
  logic [7:0]        tx_q;
  logic [6:0]        addr_q;
  logic              lsb_q;
  logic              so_q;
  logic              so_oe_n_q;
  logic              page_q;
  logic [7:0]        mem_q [0:255];
  logic              spi_on;
  logic              rise;
  logic              fall;
  logic [7:0]        nb;
  logic              wr_en;
  logic [N_STOP-1:0] stop_hw;
  logic [N_DIFF-1:0] diff_hw;
  logic [N_CMOS-1:0] cmos_hw;

  // register read as seen through the current page; 0x7F is the page select
  function automatic logic [7:0] reg_read(input logic [6:0] a);
    if (a == PAGE_ADDR) begin
      reg_read = {7'h00, page_q};
    end else begin
      reg_read = mem_q[{page_q, a}];
    end
  endfunction

  // two-flop synchronisers for every pin; select and clock add a third flop to find edges
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cs_s1_q    <= 1'b1;
      cs_s2_q    <= 1'b1;
      cs_prev_q  <= 1'b1;
      sck_s1_q   <= 1'b0;
      sck_s2_q   <= 1'b0;
      sck_prev_q <= 1'b0;
      si_s1_q    <= 1'b0;
      si_s2_q    <= 1'b0;
      gp_s1_q    <= '0;
      gp_s2_q    <= '0;
    end else begin
      cs_s1_q    <= link.chip_select_n_pin;
      cs_s2_q    <= cs_s1_q;
      cs_prev_q  <= cs_s2_q;
      sck_s1_q   <= link.serial_clk_pin;
      sck_s2_q   <= sck_s1_q;
      sck_prev_q <= sck_s2_q;
      si_s1_q    <= link.serial_in_pin;
      si_s2_q    <= si_s1_q;
      gp_s1_q    <= link.gpio_pin;
      gp_s2_q    <= gp_s1_q;
    end
  end

  // strap window: the pin level is caught once, at the end of the hold time
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      strap_cnt_q <= '0;
      strap_done  <= 1'b0;
      host_if_i2c <= 1'b0;
    end else if (!strap_done) begin
      if (strap_cnt_q == 32'(STRAP_CYCLES - 1)) begin
        strap_done  <= 1'b1;
        host_if_i2c <= gp_s2_q[STRAP_PIN];
      end else begin
        strap_cnt_q <= strap_cnt_q + 32'h1;
      end
    end
  end

  // edges of the serial clock, only seen while selected
  assign spi_on = strap_done & ~host_if_i2c;
  assign rise   = spi_on & ~cs_s2_q & sck_s2_q & ~sck_prev_q;
  assign fall   = spi_on & ~cs_s2_q & ~sck_s2_q & sck_prev_q;
  assign nb     = shift_in(sh_q, si_s2_q, lsb_q);
  assign wr_en  = (state_q == ST_WR) & rise & (cnt_q == BIT_LAST);

  // serial slave: address phase, then write or read bytes until select rises
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q   <= ST_OFF;
      cnt_q     <= '0;
      sh_q      <= '0;
      tx_q      <= '0;
      addr_q    <= '0;
      lsb_q     <= 1'b0;
      so_q      <= 1'b1;
      so_oe_n_q <= 1'b1;
    end else if (!spi_on || cs_s2_q) begin
      // state waits in ST_ADDR (ST_OFF when the link is off); bit count, shift register and output held in reset while deselected
      state_q   <= spi_on ? ST_ADDR : ST_OFF;
      cnt_q     <= '0;
      sh_q      <= '0;
      so_q      <= 1'b1;
      so_oe_n_q <= 1'b1;
    end else begin
      if (cs_prev_q) begin
        lsb_q <= sck_s2_q;
      end
      case (state_q)
        ST_OFF: begin
          state_q <= ST_OFF;
        end
        ST_ADDR: begin
          if (rise) begin
            sh_q  <= nb;
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == BIT_LAST) begin
              addr_q <= frame_addr(nb, lsb_q);
              if (frame_flag(nb, lsb_q)) begin
                state_q <= ST_RD;
                tx_q    <= reg_read(frame_addr(nb, lsb_q));
              end else begin
                state_q <= ST_WR;
              end
            end
          end
        end
        ST_WR: begin
          if (rise) begin
            sh_q  <= nb;
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == BIT_LAST) begin
              addr_q <= addr_q + 7'h01;
            end
          end
        end
        ST_RD: begin
          // input line is not looked at in this state
          if (fall) begin
            so_q      <= bit_pick(tx_q, cnt_q, lsb_q);
            so_oe_n_q <= 1'b0;
          end
          if (rise) begin
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == BIT_LAST) begin
              addr_q <= addr_q + 7'h01;
              tx_q   <= reg_read(addr_q + 7'h01);
            end
          end
        end
        default: begin
          state_q <= ST_OFF;
        end
      endcase
    end
  end

  assign link.serial_out_pin  = so_q;
  assign link.serial_out_oe_n = so_oe_n_q;

  // page select: only the flip value acts, anything else is dropped
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      page_q <= 1'b0;
    end else if (wr_en && addr_q == PAGE_ADDR && nb == PAGE_FLIP) begin
      page_q <= ~page_q;
    end
  end

  // register storage; reset contents are all zero so every output starts off
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 256; i++) begin
        mem_q[i] <= '0;
      end
    end else if (wr_en && addr_q != PAGE_ADDR) begin
      mem_q[{page_q, addr_q}] <= nb;
    end
  end

  // pin functions; a pin with code zero matches none of the groups
  always_comb begin
    logic [CODE_W-1:0] code;
    code    = '0;
    stop_hw = '0;
    diff_hw = '0;
    cmos_hw = '0;
    for (int i = 0; i < N_GPIO; i++) begin
      code = mem_q[8'(int'(GPIO_CFG_BASE) + i)][CODE_W-1:0];
      if ((code & FN_STOP_MASK) == FN_STOP_VAL) begin
        stop_hw[{code[3], code[1:0]}] = stop_hw[{code[3], code[1:0]}] | gp_s2_q[i];
      end
      if ((code & FN_DIFF_MASK) == FN_DIFF_VAL) begin
        diff_hw[code[3:2]] = diff_hw[code[3:2]] | gp_s2_q[i];
      end
      if ((code & FN_CMOS_MASK) == FN_CMOS_VAL) begin
        cmos_hw[code[2:1]] = cmos_hw[code[2:1]] | gp_s2_q[i];
      end
    end
  end

  // software bits ORed with pin requests, registered to keep outputs glitch free
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      clk_stop <= '0;
      diff_en  <= '0;
      cmos_en  <= '0;
    end else begin
      clk_stop <= mem_q[STOP_REG][N_STOP-1:0] | stop_hw;
      diff_en  <= mem_q[DIFF_EN_REG][N_DIFF-1:0] | diff_hw;
      cmos_en  <= mem_q[CMOS_EN_REG][N_CMOS-1:0] | cmos_hw;
    end
  end
endmodule // shp_device
`default_nettype wire

// *** shp_pkg.sv ***
`default_nettype none
package shp_pkg;
  // system clock and strap timing
  localparam int CLK_HZ         = 50_000_000;
  localparam int STRAP_HOLD_MS  = 50;
  localparam int STRAP_HOLD_CYC = (CLK_HZ / 1000) * STRAP_HOLD_MS;
  localparam int STRAP_PIN      = 3;

  // widths and sizes
  localparam int N_GPIO_DEF  = 8;
  localparam int ADDR_W      = 7;
  localparam int DATA_W      = 8;
  localparam int CODE_W      = 7;
  localparam int N_STOP      = 8;
  localparam int N_DIFF      = 4;
  localparam int N_CMOS      = 4;
  localparam int SCK_HALF    = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // device register space
  localparam logic [ADDR_W-1:0] PAGE_ADDR     = 7'h7F;
  localparam logic [DATA_W-1:0] PAGE_FLIP     = 8'h01;
  localparam logic [DATA_W-1:0] STOP_REG      = 8'h20;
  localparam logic [DATA_W-1:0] DIFF_EN_REG   = 8'h21;
  localparam logic [DATA_W-1:0] CMOS_EN_REG   = 8'h22;
  localparam logic [DATA_W-1:0] GPIO_CFG_BASE = 8'h30;

  // pin function codes: match when (code & mask) == value
  localparam logic [CODE_W-1:0] FN_STOP_MASK = 7'h74;
  localparam logic [CODE_W-1:0] FN_STOP_VAL  = 7'h44;
  localparam logic [CODE_W-1:0] FN_DIFF_MASK = 7'h73;
  localparam logic [CODE_W-1:0] FN_DIFF_VAL  = 7'h60;
  localparam logic [CODE_W-1:0] FN_CMOS_MASK = 7'h79;
  localparam logic [CODE_W-1:0] FN_CMOS_VAL  = 7'h70;

  // host controller registers (byte addresses)
  localparam logic [7:0] HR_CTRL   = 8'h00;
  localparam logic [7:0] HR_ADDR   = 8'h04;
  localparam logic [7:0] HR_WDATA  = 8'h08;
  localparam logic [7:0] HR_RDATA  = 8'h0C;
  localparam logic [7:0] HR_STATUS = 8'h10;
  localparam int CTL_GO   = 0;
  localparam int CTL_READ = 1;
  localparam int CTL_LSB  = 2;
  localparam int CTL_LAST = 3;

  // bit of a byte sent at position idx of the chosen order
  function automatic logic bit_pick(input logic [7:0] b, input logic [2:0] idx, input logic lsb);
    bit_pick = lsb ? b[idx] : b[3'h7 - idx];
  endfunction

  // shift a received bit into a byte in the chosen order
  function automatic logic [7:0] shift_in(input logic [7:0] b, input logic d, input logic lsb);
    shift_in = lsb ? {d, b[7:1]} : {b[6:0], d};
  endfunction

  // first byte: flag is sent first, then the address
  function automatic logic [7:0] frame_pack(input logic rd, input logic [6:0] a, input logic lsb);
    frame_pack = lsb ? {a, rd} : {rd, a};
  endfunction

  function automatic logic frame_flag(input logic [7:0] b, input logic lsb);
    frame_flag = lsb ? b[0] : b[7];
  endfunction

  function automatic logic [6:0] frame_addr(input logic [7:0] b, input logic lsb);
    frame_addr = lsb ? b[7:1] : b[6:0];
  endfunction
endpackage
`default_nettype wire

// *** spi_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface spi_if #(
  parameter int N_GPIO = shp_pkg::N_GPIO_DEF
) ();
  logic              chip_select_n_pin;
  logic              serial_clk_pin;
  logic              serial_in_pin;
  logic              serial_out_pin;
  logic              serial_out_oe_n;
  logic              serial_out_line;
  logic [N_GPIO-1:0] gpio_pin;

  // released output reads high, as with a pull-up
  assign serial_out_line = serial_out_oe_n ? 1'b1 : serial_out_pin;

  modport dev (
    input  chip_select_n_pin,
    input  serial_clk_pin,
    input  serial_in_pin,
    input  gpio_pin,
    output serial_out_pin,
    output serial_out_oe_n
  );

  modport host (
    output chip_select_n_pin,
    output serial_clk_pin,
    output serial_in_pin,
    output gpio_pin,
    input  serial_out_line
  );
endinterface
`default_nettype wire

// *** shp_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module shp_host #(
  parameter int N_GPIO       = shp_pkg::N_GPIO_DEF,
  parameter int STRAP_CYCLES = shp_pkg::STRAP_HOLD_CYC,
  parameter int HALF_CYC     = shp_pkg::SCK_HALF
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  // wishbone slave
  input  wire logic              wb_cyc,
  input  wire logic              wb_stb,
  input  wire logic              wb_we,
  input  wire logic [7:0]        wb_adr,
  input  wire logic [3:0]        wb_sel,
  input  wire logic [31:0]       wb_dat_wr,
  output logic [31:0]            wb_dat_rd,
  output logic                   wb_ack,
  // user pin levels
  input  wire logic [N_GPIO-1:0] gpio_level,
  input  wire logic              strap_i2c,
  // serial link
  spi_if.host                    link
);
  import shp_pkg::*;

  typedef enum logic [6:0] {
    H_IDLE  = 7'b0000001,
    H_SETUP = 7'b0000010,
    H_CSLOW = 7'b0000100,
    H_LOW   = 7'b0001000,
    H_HIGH  = 7'b0010000,
    H_HOLD  = 7'b0100000,
    H_END   = 7'b1000000
  } host_state_t;

  host_state_t st_q;
  logic [31:0] strap_cnt_q;
  logic        strap_hold_q;
  logic [6:0]  addr_q;
  logic [7:0]  wdata_q, rdata_q, tx_q, rx_q;
  logic        read_q, lsb_q, last_q, in_addr_q;
  logic [2:0]  bit_q;
  logic [15:0] div_q;
  logic        tick, acc, go;
  logic        so_s1_q, so_s2_q;
  logic        cs_n_q, sck_q, si_q;
  logic [N_GPIO-1:0] gpio_q;

  assign tick = div_q == 16'(HALF_CYC - 1);
  assign acc  = wb_cyc & wb_stb & ~wb_ack;
  assign go   = acc & wb_we & wb_sel[0] & (wb_adr == HR_CTRL) & wb_dat_wr[CTL_GO];

  // strap level held on its pin through the hold window, then user level
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      strap_cnt_q  <= '0;
      strap_hold_q <= 1'b1;
      gpio_q       <= '0;
    end else begin
      if (strap_hold_q) begin
        strap_cnt_q <= strap_cnt_q + 32'h1;
        if (strap_cnt_q == 32'(STRAP_CYCLES)) begin
          strap_hold_q <= 1'b0;
        end
      end
      gpio_q <= gpio_level;
      if (strap_hold_q) begin
        gpio_q[STRAP_PIN] <= strap_i2c;
      end
    end
  end

  // wishbone: one wait state, ack for one cycle; unmapped reads give zero
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack    <= 1'b0;
      wb_dat_rd <= '0;
      addr_q    <= '0;
      wdata_q   <= '0;
    end else begin
      wb_ack    <= acc;
      wb_dat_rd <= '0;
      if (acc && wb_we && wb_sel[0] && wb_adr == HR_ADDR) begin
        addr_q <= wb_dat_wr[ADDR_W-1:0];
      end
      if (acc && wb_we && wb_sel[0] && wb_adr == HR_WDATA) begin
        wdata_q <= wb_dat_wr[DATA_W-1:0];
      end
      if (acc && !wb_we) begin
        case (wb_adr)
          HR_ADDR:   wb_dat_rd <= 32'(addr_q);
          HR_WDATA:  wb_dat_rd <= 32'(wdata_q);
          HR_RDATA:  wb_dat_rd <= 32'(rdata_q);
          HR_STATUS: wb_dat_rd <= 32'({strap_hold_q, ~cs_n_q, (st_q != H_IDLE && st_q != H_HOLD)});
          default:   wb_dat_rd <= '0;
        endcase
      end
    end
  end

  // serial return line is a pin, so it is synchronised first
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      so_s1_q <= 1'b1;
      so_s2_q <= 1'b1;
    end else begin
      so_s1_q <= link.serial_out_line;
      so_s2_q <= so_s1_q;
    end
  end

  // master sequencer: sck made by dividing clk_sys, return line sampled at the end of its high half
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= H_IDLE;
      div_q <= '0;
      cs_n_q <= 1'b1;
      sck_q <= 1'b0;
      si_q <= 1'b0;
      bit_q <= '0;
      tx_q <= '0;
      rx_q <= '0;
      rdata_q <= '0;
      read_q <= 1'b0;
      lsb_q <= 1'b0;
      last_q <= 1'b0;
      in_addr_q <= 1'b0;
    end else begin
      div_q <= (st_q == H_IDLE || st_q == H_HOLD || tick) ? '0 : div_q + 16'h1;
      case (st_q)
        H_IDLE: begin
          if (go) begin
            read_q    <= wb_dat_wr[CTL_READ];
            lsb_q     <= wb_dat_wr[CTL_LSB];
            last_q    <= wb_dat_wr[CTL_LAST];
            sck_q     <= wb_dat_wr[CTL_LSB];
            tx_q      <= frame_pack(wb_dat_wr[CTL_READ], addr_q, wb_dat_wr[CTL_LSB]);
            in_addr_q <= 1'b1;
            bit_q     <= '0;
            st_q      <= H_SETUP;
          end
        end
        H_SETUP: if (tick) begin
          cs_n_q <= 1'b0;
          st_q   <= H_CSLOW;
        end
        H_CSLOW: if (tick) st_q <= H_LOW;
        H_LOW: begin
          sck_q <= 1'b0;
          si_q  <= bit_pick(tx_q, bit_q, lsb_q);
          if (tick) st_q <= H_HIGH;
        end
        H_HIGH: begin
          sck_q <= 1'b1;
          if (tick) begin
            rx_q  <= shift_in(rx_q, so_s2_q, lsb_q);
            bit_q <= bit_q + 3'h1;
            st_q  <= H_LOW;
            if (bit_q == BIT_LAST) begin
              if (in_addr_q) begin
                in_addr_q <= 1'b0;
                tx_q      <= wdata_q;
              end else begin
                if (read_q) rdata_q <= shift_in(rx_q, so_s2_q, lsb_q);
                st_q <= last_q ? H_END : H_HOLD;
              end
            end
          end
        end
        H_HOLD: begin
          // select stays low so the next byte continues the burst
          if (go) begin
            last_q <= wb_dat_wr[CTL_LAST];
            tx_q   <= wdata_q;
            st_q   <= H_LOW;
          end
        end
        H_END: begin
          sck_q <= lsb_q;
          if (tick) begin
            cs_n_q <= 1'b1;
            st_q   <= H_IDLE;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  assign link.chip_select_n_pin = cs_n_q;
  assign link.serial_clk_pin    = sck_q;
  assign link.serial_in_pin     = si_q;
  assign link.gpio_pin          = gpio_q;
endmodule // shp_host
`default_nettype wire

// *** shp_link_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module shp_link_assertions #(
  parameter int N_GPIO       = shp_pkg::N_GPIO_DEF,
  parameter int STRAP_CYCLES = shp_pkg::STRAP_HOLD_CYC
) (
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              arst_n,
  // link wires
  input wire logic              chip_select_n_pin,
  input wire logic              serial_clk_pin,
  input wire logic              serial_in_pin,
  input wire logic              serial_out_pin,
  input wire logic              serial_out_oe_n,
  input wire logic [N_GPIO-1:0] gpio_pin
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic [7:0]  bits_q;
  logic        flag_q;
  logic [31:0] age_q;
  // bit count and direction flag of a frame, cleared while deselected
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bits_q <= 8'h00;
      flag_q <= 1'b0;
    end else if (chip_select_n_pin) begin
      bits_q <= 8'h00;
      flag_q <= 1'b0;
    end else if ($rose(serial_clk_pin) && bits_q != 8'hFF) begin
      bits_q <= bits_q + 8'h01;
      flag_q <= (bits_q == 8'h00) ? serial_in_pin : flag_q;
    end
  end
  // edges since reset release; saturates so long runs never wrap
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      age_q <= 32'h0;
    end else if (age_q != 32'hFFFF_FFFF) begin
      age_q <= age_q + 32'h1;
    end
  end
  cs_idle_oe_a: assert property (chip_select_n_pin [*5] |-> serial_out_oe_n)
    else $error("serial output driven while deselected");
  order_lock_a: assert property ($fell(chip_select_n_pin) |-> ##1 $stable(serial_clk_pin) [*7])
    else $error("clock moved right after select fell");
  sck_high_a: assert property ($rose(serial_clk_pin) && !chip_select_n_pin |-> serial_clk_pin [*8])
    else $error("clock high half too short");
  si_stable_a: assert property ($rose(serial_clk_pin) && !chip_select_n_pin |-> $stable(serial_in_pin) [*8])
    else $error("serial input moved while clock high");
  out_stable_a: assert property ($rose(serial_clk_pin) && !serial_out_oe_n |-> $stable(serial_out_pin) [*8])
    else $error("serial output moved while clock high");
  strap_hold_a: assert property (age_q >= 32'h2 && age_q <= STRAP_CYCLES |-> $stable(gpio_pin[3]))
    else $error("strap pin moved inside hold window");
  addr_quiet_a: assert property (!chip_select_n_pin && bits_q < 8'h08 |-> serial_out_oe_n)
    else $error("device drove during address phase");
  read_drive_a: assert property ($fell(serial_clk_pin) && !chip_select_n_pin && flag_q && bits_q >= 8'h08
    && bits_q[2:0] != 3'h0 |-> ##[1:4] !serial_out_oe_n)
    else $error("device silent during read data");
  cover property ($fell(chip_select_n_pin) && serial_clk_pin);
  cover property ($fell(chip_select_n_pin) && !serial_clk_pin);
  cover property (!chip_select_n_pin && flag_q && !serial_out_oe_n);
  cover property (!chip_select_n_pin && bits_q == 8'h18);
endmodule  // shp_link_assertions
`default_nettype wire

// *** tb_serial_host_port_gpio_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_serial_host_port_gpio_ctrl;
  import shp_pkg::*;
  localparam int STRAP = 20;  // short strap window keeps the run brief
  logic        clk_sys, arst_n, wb_cyc, wb_stb, wb_we, wb_ack, strap_i2c;
  logic [7:0]  wb_adr, gpio_level, clk_stop, rv;
  logic [31:0] wb_dat_wr, wb_dat_rd, rd_v;
  logic [3:0]  diff_en, cmos_en, wb_sel;
  logic        strap_done, host_if_i2c, at_fall_q, sck_q, cs_q;
  logic [15:0] cap_q;
  int          n_fail, n_compared;
  // code, pin level, expected {clk_stop, diff_en, cmos_en}
  logic [27:0] rows [20] = '{
    28'h00_1_0000, 28'h44_1_0100, 28'h45_1_0200, 28'h46_1_0400, 28'h47_1_0800,
    28'h4C_1_1000, 28'h4D_1_2000, 28'h4E_1_4000, 28'h4F_1_8000, 28'h44_0_0000,
    28'hC4_1_0100, 28'h48_1_0000, 28'h60_1_0010, 28'h64_1_0020, 28'h68_1_0040,
    28'h6C_1_0080, 28'h70_1_0001, 28'h72_1_0002, 28'h74_1_0004, 28'h76_1_0008};
  spi_if #(.N_GPIO(8)) spi_if_inst ();
  shp_device #(.N_GPIO(8), .STRAP_CYCLES(STRAP)) shp_device_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .link(spi_if_inst), .clk_stop(clk_stop), .diff_en(diff_en),
    .cmos_en(cmos_en), .strap_done(strap_done), .host_if_i2c(host_if_i2c));
  shp_host #(.N_GPIO(8), .STRAP_CYCLES(STRAP), .HALF_CYC(8)) shp_host_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_wr(wb_dat_wr), .wb_dat_rd(wb_dat_rd), .wb_ack(wb_ack),
    .gpio_level(gpio_level), .strap_i2c(strap_i2c), .link(spi_if_inst));
  shp_link_assertions #(.N_GPIO(8), .STRAP_CYCLES(STRAP)) shp_link_assertions_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .chip_select_n_pin(spi_if_inst.chip_select_n_pin),
    .serial_clk_pin(spi_if_inst.serial_clk_pin), .serial_in_pin(spi_if_inst.serial_in_pin),
    .serial_out_pin(spi_if_inst.serial_out_pin), .serial_out_oe_n(spi_if_inst.serial_out_oe_n),
    .gpio_pin(spi_if_inst.gpio_pin));
  // 50 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // wire monitor: bits taken at clock rise, clock level at select fall
  always @(posedge clk_sys) begin
    sck_q <= spi_if_inst.serial_clk_pin;
    cs_q <= spi_if_inst.chip_select_n_pin;
    if (cs_q && !spi_if_inst.chip_select_n_pin) begin
      cap_q <= 16'h0000;
      at_fall_q <= spi_if_inst.serial_clk_pin;
    end else if (!spi_if_inst.chip_select_n_pin && spi_if_inst.serial_clk_pin && !sck_q) begin
      cap_q <= {cap_q[14:0], spi_if_inst.serial_in_pin};
    end
  end
  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one classic cycle; the request holds until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_wr <= wd;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (wb_ack !== 1'b1) begin
      n_fail++;
      end_sim();
    end
    rd = wb_dat_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wbw(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb_xfer(1'b1, a, {24'h0, d}, r);
  endtask
  // start a byte and poll until the host is idle or holding the burst
  task automatic go(input logic [7:0] c);
    int n;
    n = 0;
    wbw(HR_CTRL, c);
    do begin
      wb_xfer(1'b0, HR_STATUS, 32'h0, rd_v);
      n++;
    end while (rd_v[0] !== 1'b0 && n < 400);
    if (rd_v[0] !== 1'b0) begin
      n_fail++;
      end_sim();
    end
  endtask
  task automatic dev_wr(input logic [7:0] a, input logic [7:0] d, input logic lsb);
    wbw(HR_ADDR, a);
    wbw(HR_WDATA, d);
    go({5'h01, lsb, 2'h1});
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic lsb, input logic [7:0] e);
    wbw(HR_ADDR, a);
    go({5'h01, lsb, 2'h3});
    wb_xfer(1'b0, HR_RDATA, 32'h0, rd_v);
    check(rd_v[7:0], e);
  endtask
  // outputs are registered: allow a few edges to settle
  task automatic expect_out(input logic [15:0] e);
    int n;
    n = 0;
    while ({clk_stop, diff_en, cmos_en} !== e && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    check({clk_stop, diff_en, cmos_en}, e);
  endtask
  task automatic reset_dut(input logic s);
    int n;
    n = 0;
    arst_n <= 1'b0;
    strap_i2c <= s;
    repeat (2) @(posedge clk_sys);
    check({clk_stop, diff_en, cmos_en, spi_if_inst.serial_out_oe_n}, 17'h1);
    check(spi_if_inst.chip_select_n_pin, 1'b1);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    check(strap_done, 1'b0);
    while (strap_done !== 1'b1 && n < STRAP + 10) begin
      @(posedge clk_sys);
      n++;
    end
    check({strap_done, host_if_i2c}, {1'b1, s});
  endtask
  initial begin
    n_fail = 0;
    n_compared = 0;
    arst_n = 1'b0;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_wr} = '0;
    wb_sel = 4'hF;
    gpio_level = 8'h00;
    strap_i2c = 1'b0;
    reset_dut(1'b0);
    wb_xfer(1'b0, 8'h20, 32'h0, rd_v);
    check(rd_v, 32'h0);
    // table of pin function codes, bit orders alternating
    for (int i = 0; i < 20; i++) begin
      gpio_level <= {7'h04, rows[i][16]};
      dev_wr(GPIO_CFG_BASE, rows[i][27:20], i[0]);
      expect_out(rows[i][15:0]);
    end
    check(host_if_i2c, 1'b0);
    // software bits ORed with a pin enable
    dev_wr(STOP_REG, 8'h80, 1'b0);
    dev_wr(DIFF_EN_REG, 8'h02, 1'b1);
    dev_wr(CMOS_EN_REG, 8'h04, 1'b0);
    dev_wr(GPIO_CFG_BASE, 8'h60, 1'b0);
    expect_out(16'h8034);
    gpio_level <= 8'h00;
    expect_out(16'h8024);
    dev_wr(GPIO_CFG_BASE, 8'h44, 1'b1);
    gpio_level <= 8'h01;
    expect_out(16'h8124);
    dev_wr(GPIO_CFG_BASE, 8'h00, 1'b1);
    // wire order in both modes
    dev_wr(DIFF_EN_REG, 8'h0F, 1'b1);
    check({at_fall_q, cap_q}, 17'h142F0);
    dev_wr(CMOS_EN_REG, 8'h0A, 1'b0);
    check({at_fall_q, cap_q}, 17'h0220A);
    expect_out(16'h80FA);
    rd_chk(STOP_REG, 1'b1, 8'h80);
    rd_chk(CMOS_EN_REG, 1'b0, 8'h0A);
    // burst write then burst read across three locations
    wbw(HR_ADDR, STOP_REG);
    for (int k = 0; k < 3; k++) begin
      wbw(HR_WDATA, 8'h11 >> (k * 2));
      go(k == 2 ? 8'h09 : 8'h01);
    end
    expect_out(16'h1141);
    wbw(HR_ADDR, STOP_REG);
    for (int k = 0; k < 3; k++) begin
      go(k == 2 ? 8'h0F : 8'h07);
      wb_xfer(1'b0, HR_RDATA, 32'h0, rd_v);
      check(rd_v, 32'h11 >> (k * 2));
    end
    // paging: only 0x01 flips, page 1 leaves page 0 registers alone
    dev_wr(PAGE_ADDR, PAGE_FLIP, 1'b0);
    rd_chk(PAGE_ADDR, 1'b0, 8'h01);
    dev_wr(STOP_REG, 8'hFF, 1'b0);
    expect_out(16'h1141);
    dev_wr(PAGE_ADDR, 8'h02, 1'b1);
    rd_chk(PAGE_ADDR, 1'b1, 8'h01);
    dev_wr(PAGE_ADDR, PAGE_FLIP, 1'b1);
    rd_chk(PAGE_ADDR, 1'b0, 8'h00);
    rd_chk(STOP_REG, 1'b0, 8'h11);
    // a write with byte lane 0 off leaves the address register alone
    wb_sel <= 4'h0;
    wbw(HR_ADDR, 8'h55);
    wb_sel <= 4'hF;
    wb_xfer(1'b0, HR_ADDR, 32'h0, rd_v);
    check(rd_v, {24'h0, STOP_REG});
    // second reset with the strap high: serial slave stays off
    gpio_level <= 8'h00;
    reset_dut(1'b1);
    dev_wr(STOP_REG, 8'hFF, 1'b0);
    expect_out(16'h0000);
    end_sim();
  end
endmodule  // tb_serial_host_port_gpio_ctrl
`default_nettype wire
